// File: common/addr_phase_pkg.sv
// Package for the processor bus address phase: widths, timing and states.
// Assumes one bus clock shared by both ends and a synchronous high reset.
package addr_phase_pkg;
  localparam int ADDR_HI = 31;
  localparam int ADDR_LO = 3;
  localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
  localparam int SNOOP_LO = 5;
  localparam int MASK_BIT = 20;
  localparam int BE_W = 8;
  localparam int ERR_DELAY = 2;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 29'h0;
  localparam logic [BE_W-1:0] BE_IDLE = 8'hff;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_HOLD = 2'b10
  } dev_state_t;
endpackage

// File: common/addr_phase_if.sv
// Interface joining the processor end and the system end of the address phase.
// Resolves shared address and parity wires from the two output enables.
`timescale 1ns/1ps
`default_nettype none
interface addr_phase_if (
  input wire logic sys_clk_i
);
  logic [addr_phase_pkg::ADDR_W-1:0] dev_addr;
  logic dev_addr_oe;
  logic dev_par;
  logic [addr_phase_pkg::ADDR_W-1:0] sys_addr;
  logic sys_addr_oe;
  logic sys_par;
  logic [addr_phase_pkg::BE_W-1:0] byte_enable_n;
  logic new_cycle_strobe_n;
  logic cycle_strobe_copy_n;
  logic address_float_request;
  logic external_snoop_strobe_n;
  logic inquire_parity_error_n;
  logic address_bit20_mask_n;
  logic interrupt_bus_data1;
  logic [addr_phase_pkg::ADDR_W-1:0] address_lines;
  logic address_parity;
  // Pull-up on undriven wires
  assign address_lines = dev_addr_oe ? dev_addr : (sys_addr_oe ? sys_addr : '1);
  assign address_parity = dev_addr_oe ? dev_par : (sys_addr_oe ? sys_par : 1'b1);
  modport device (
    input sys_clk_i, address_lines, address_parity, address_float_request,
    input external_snoop_strobe_n, address_bit20_mask_n, interrupt_bus_data1,
    output dev_addr, dev_addr_oe, dev_par, byte_enable_n,
    output new_cycle_strobe_n, cycle_strobe_copy_n, inquire_parity_error_n
  );
  modport system (
    input sys_clk_i, address_lines, address_parity, byte_enable_n,
    input new_cycle_strobe_n, cycle_strobe_copy_n, inquire_parity_error_n,
    output sys_addr, sys_addr_oe, sys_par, address_float_request,
    output external_snoop_strobe_n, address_bit20_mask_n, interrupt_bus_data1
  );
endinterface
`default_nettype wire

// File: hw/addr_phase_device.sv
// Processor end of the bus address phase: drives cycles, checks snoop parity.
// Assumes bus pins reach it already synchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Mask forces address bit 20 to zero
// - System asserts mask only in real mode
// - Dual processor ignores the mask input
// - Device drives address lines 31 to 3
// - System drives snoop address on 31..5
// - New-cycle strobe marks a valid cycle
// - Copy strobe mirrors the new-cycle strobe
// - Float address and parity after hold
// - Rest of bus stays active during hold
// - Even parity driven with the address
// - System drives even snoop parity too
// - Parity error flagged two clocks later
// - Error output lasts exactly one clock
// - Strap sampled at reset falling edge
// - Dual mode makes shared pins bidirectional
// - Active-low signals assert at low level
// - Byte enables driven with the address
module addr_phase_device (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  addr_phase_if.device bus,
  input wire logic dual_mode_i,
  input wire logic cycle_req_i,
  input wire logic [31:0] cycle_addr_i,
  input wire logic [7:0] cycle_be_i,
  output logic cycle_ack_o,
  output logic [31:0] lookup_addr_o,
  output logic snoop_valid_o,
  output logic [31:0] snoop_addr_o,
  output logic intctl_enable_o,
  output logic dual_strobe_oe_o
);
  localparam int AW = addr_phase_pkg::ADDR_W;
  // Output register adds the last clock of the error delay
  localparam int ERR_STAGE = addr_phase_pkg::ERR_DELAY - 2;
  addr_phase_pkg::dev_state_t state_reg, state_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic oe_reg, oe_next;
  logic par_reg, par_next;
  logic [7:0] be_reg, be_next;
  logic ads_reg, ads_next;
  logic ack_reg, ack_next;
  logic [31:0] lookup_reg, lookup_next;
  logic [ERR_STAGE:0] err_pipe_reg, err_pipe_next;
  logic err_reg, err_next;
  logic snoop_v_reg, snoop_v_next;
  logic [31:0] snoop_reg, snoop_next;
  logic strap_reg, strap_next;
  logic rst_d_reg;
  logic [31:0] masked_addr;
  logic snoop_hit;
  logic dual_reg;

  always_comb begin
    masked_addr = cycle_addr_i;
    if (!bus.address_bit20_mask_n && !dual_reg) begin
      masked_addr[addr_phase_pkg::MASK_BIT] = 1'b0;
    end
  end

  assign snoop_hit = !bus.external_snoop_strobe_n;

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    oe_next = oe_reg;
    par_next = par_reg;
    be_next = addr_phase_pkg::BE_IDLE;
    ads_next = 1'b1;
    ack_next = 1'b0;
    lookup_next = lookup_reg;
    case (state_reg)
      addr_phase_pkg::ST_IDLE: begin
        if (bus.address_float_request) begin
          oe_next = 1'b0;
          state_next = addr_phase_pkg::ST_HOLD;
        end else if (cycle_req_i) begin
          addr_next = masked_addr[addr_phase_pkg::ADDR_HI:addr_phase_pkg::ADDR_LO];
          par_next = ^masked_addr[addr_phase_pkg::ADDR_HI:addr_phase_pkg::ADDR_LO];
          be_next = ~cycle_be_i;
          ads_next = 1'b0;
          oe_next = 1'b1;
          ack_next = 1'b1;
          lookup_next = masked_addr;
          state_next = addr_phase_pkg::ST_ADDR;
        end
      end
      addr_phase_pkg::ST_ADDR: begin
        // Address stays on the pins after the strobe until hold or next cycle
        if (bus.address_float_request) begin
          oe_next = 1'b0;
          state_next = addr_phase_pkg::ST_HOLD;
        end else begin
          state_next = addr_phase_pkg::ST_IDLE;
        end
      end
      addr_phase_pkg::ST_HOLD: begin
        // Only the address group floats; other outputs keep running
        oe_next = 1'b0;
        if (!bus.address_float_request) begin
          state_next = addr_phase_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = addr_phase_pkg::ST_IDLE;
        oe_next = 1'b0;
      end
    endcase
  end

  always_comb begin
    snoop_v_next = 1'b0;
    snoop_next = snoop_reg;
    err_pipe_next = err_pipe_reg << 1;
    err_next = 1'b1;
    if (snoop_hit) begin
      snoop_v_next = 1'b1;
      snoop_next = {bus.address_lines[AW-1:addr_phase_pkg::SNOOP_LO-addr_phase_pkg::ADDR_LO],
                    5'h00};
      // Even parity over the sampled lines plus the parity pin
      err_pipe_next[0] = ^{bus.address_lines, bus.address_parity};
    end
    // Stage count set so the flag lands two clocks after the strobe
    if (err_pipe_reg[ERR_STAGE]) begin
      err_next = 1'b0;
    end
    strap_next = strap_reg;
    if (rst_d_reg && !rst_i) begin
      strap_next = bus.interrupt_bus_data1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    rst_d_reg <= rst_i;
    strap_reg <= strap_next;
    dual_reg <= dual_mode_i;
    if (rst_i) begin
      state_reg <= addr_phase_pkg::ST_IDLE;
      addr_reg <= addr_phase_pkg::ADDR_RESET;
      oe_reg <= 1'b0;
      par_reg <= 1'b0;
      be_reg <= addr_phase_pkg::BE_IDLE;
      ads_reg <= 1'b1;
      ack_reg <= 1'b0;
      lookup_reg <= 32'h0;
      err_pipe_reg <= '0;
      err_reg <= 1'b1;
      snoop_v_reg <= 1'b0;
      snoop_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      oe_reg <= oe_next;
      par_reg <= par_next;
      be_reg <= be_next;
      ads_reg <= ads_next;
      ack_reg <= ack_next;
      lookup_reg <= lookup_next;
      err_pipe_reg <= err_pipe_next;
      err_reg <= err_next;
      snoop_v_reg <= snoop_v_next;
      snoop_reg <= snoop_next;
    end
  end

  assign bus.dev_addr = addr_reg;
  assign bus.dev_addr_oe = oe_reg;
  assign bus.dev_par = par_reg;
  assign bus.byte_enable_n = be_reg;
  assign bus.new_cycle_strobe_n = ads_reg;
  assign bus.cycle_strobe_copy_n = ads_reg;
  assign bus.inquire_parity_error_n = err_reg;
  assign cycle_ack_o = ack_reg;
  assign lookup_addr_o = lookup_reg;
  assign snoop_valid_o = snoop_v_reg;
  assign snoop_addr_o = snoop_reg;
  assign intctl_enable_o = strap_reg;
  // Dual mode turns shared strobes into two-way pins
  assign dual_strobe_oe_o = dual_reg;
endmodule
`default_nettype wire

// File: hw/addr_phase_system.sv
// System end of the address phase: issues snoops, holds the address bus.
// Assumes the processor end shares sys_clk_i through the interface.
`timescale 1ns/1ps
`default_nettype none
module addr_phase_system (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  addr_phase_if.system bus,
  input wire logic real_mode_i,
  input wire logic mask_req_i,
  input wire logic hold_req_i,
  input wire logic snoop_req_i,
  input wire logic [31:0] snoop_addr_i,
  input wire logic strap_i,
  output logic cycle_seen_o,
  output logic [31:0] cycle_addr_o,
  output logic parity_err_o
);
  localparam int AW = addr_phase_pkg::ADDR_W;
  logic [AW-1:0] addr_reg, addr_next;
  logic oe_reg, oe_next;
  logic par_reg, par_next;
  logic external_snoop_strobe_reg, external_snoop_strobe_next;
  logic hold_reg, hold_next;
  logic mask_reg, mask_next;
  logic seen_reg, seen_next;
  logic [31:0] caddr_reg, caddr_next;
  logic perr_reg, perr_next;
  logic [AW-1:0] snoop_lines;

  assign snoop_lines = {snoop_addr_i[addr_phase_pkg::ADDR_HI:addr_phase_pkg::SNOOP_LO], 2'b00};

  always_comb begin
    hold_next = hold_req_i | snoop_req_i;
    mask_next = !(mask_req_i && real_mode_i);
    external_snoop_strobe_next = 1'b1;
    oe_next = 1'b0;
    addr_next = addr_reg;
    par_next = par_reg;
    // Snoop only once the system's own hold request has been registered for a clock
    if (snoop_req_i && hold_reg) begin
      external_snoop_strobe_next = 1'b0;
      oe_next = 1'b1;
      addr_next = snoop_lines;
      par_next = ^snoop_lines;
    end
    seen_next = !bus.new_cycle_strobe_n;
    caddr_next = caddr_reg;
    if (!bus.new_cycle_strobe_n) begin
      caddr_next = {bus.address_lines, 3'h0};
    end
    perr_next = !bus.inquire_parity_error_n;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      addr_reg <= addr_phase_pkg::ADDR_RESET;
      oe_reg <= 1'b0;
      par_reg <= 1'b0;
      external_snoop_strobe_reg <= 1'b1;
      hold_reg <= 1'b0;
      mask_reg <= 1'b1;
      seen_reg <= 1'b0;
      caddr_reg <= 32'h0;
      perr_reg <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      oe_reg <= oe_next;
      par_reg <= par_next;
      external_snoop_strobe_reg <= external_snoop_strobe_next;
      hold_reg <= hold_next;
      mask_reg <= mask_next;
      seen_reg <= seen_next;
      caddr_reg <= caddr_next;
      perr_reg <= perr_next;
    end
  end

  assign bus.sys_addr = addr_reg;
  assign bus.sys_addr_oe = oe_reg;
  assign bus.sys_par = par_reg;
  assign bus.external_snoop_strobe_n = external_snoop_strobe_reg;
  assign bus.address_float_request = hold_reg;
  assign bus.address_bit20_mask_n = mask_reg;
  // Strap driven straight through so it is stable across reset release
  assign bus.interrupt_bus_data1 = strap_i;
  assign cycle_seen_o = seen_reg;
  assign cycle_addr_o = caddr_reg;
  assign parity_err_o = perr_reg;
endmodule
`default_nettype wire

// File: sim/addr_phase_chk.sv
// Checker for the address phase wires between the two ends.
// Assumes one bus clock and a synchronous high reset.
`timescale 1ns/1ps
`default_nettype none
module addr_phase_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [addr_phase_pkg::ADDR_W-1:0] dev_addr,
  input wire logic dev_addr_oe,
  input wire logic dev_par,
  input wire logic [addr_phase_pkg::BE_W-1:0] byte_enable_n,
  input wire logic new_cycle_strobe_n,
  input wire logic cycle_strobe_copy_n,
  input wire logic address_float_request,
  input wire logic external_snoop_strobe_n,
  input wire logic inquire_parity_error_n,
  input wire logic [addr_phase_pkg::ADDR_W-1:0] address_lines,
  input wire logic address_parity
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_copy_strobe_same: assert property (cycle_strobe_copy_n == new_cycle_strobe_n)
    else $error("copy strobe differs from new cycle strobe");
  a_reset_idle: assert property (disable iff (1'b0) rst_i |=> new_cycle_strobe_n && !dev_addr_oe)
    else $error("bus not idle after reset");
  a_strobe_one_clock: assert property (!new_cycle_strobe_n |=> new_cycle_strobe_n)
    else $error("strobe longer than one clock");
  a_addr_with_strobe: assert property (!new_cycle_strobe_n |-> dev_addr_oe)
    else $error("strobe without driven address");
  a_even_addr_parity: assert property (dev_addr_oe |-> !(^{dev_addr, dev_par}))
    else $error("odd address parity");
  a_float_next_clock: assert property (address_float_request |=> !dev_addr_oe)
    else $error("address still driven under hold");
  a_be_with_addr: assert property (byte_enable_n != 8'hff |-> !new_cycle_strobe_n)
    else $error("byte enables outside address clock");
  a_perr_quiet_even: assert property (!external_snoop_strobe_n &&
    !(^{address_lines, address_parity}) |-> ##2 inquire_parity_error_n)
    else $error("parity error on even snoop");
  a_perr_after_snoop: assert property ($fell(inquire_parity_error_n) |->
    !$past(external_snoop_strobe_n, 2))
    else $error("parity error without snoop two clocks before");
  a_perr_one_clock: assert property (!inquire_parity_error_n |=> inquire_parity_error_n)
    else $error("parity error longer than one clock");
  c_cycle: cover property (!new_cycle_strobe_n);
  c_snoop: cover property (!external_snoop_strobe_n);
  c_float: cover property (address_float_request ##1 !dev_addr_oe);
endmodule
`default_nettype wire

// File: sim/addr_phase_tb_top.sv
// Bench for both address phase ends; a second device faces bench-driven snoops.
// Assumes package and interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module addr_phase_tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic dual = 1'b0, creq = 1'b0, rm = 1'b0, mr = 1'b0, hr = 1'b0, sr = 1'b0, strap = 1'b1;
  logic [31:0] caddr = 32'h0, saddr = 32'h0, lka, sa, sca;
  logic [7:0] cbe = 8'h0, be_seen;
  logic ack, sv, ien, ien2, doe, seen, perr;
  int mismatches = 0;
  int tests_run = 0;
  int i;
  addr_phase_if ifa (.sys_clk_i(sys_clk_i));
  addr_phase_if ifb (.sys_clk_i(sys_clk_i));
  addr_phase_device addr_phase_device_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(ifa),
    .dual_mode_i(dual), .cycle_req_i(creq), .cycle_addr_i(caddr), .cycle_be_i(cbe),
    .cycle_ack_o(ack), .lookup_addr_o(lka), .snoop_valid_o(sv), .snoop_addr_o(sa),
    .intctl_enable_o(ien), .dual_strobe_oe_o(doe));
  addr_phase_system addr_phase_system_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(ifa),
    .real_mode_i(rm), .mask_req_i(mr), .hold_req_i(hr), .snoop_req_i(sr),
    .snoop_addr_i(saddr), .strap_i(strap), .cycle_seen_o(seen), .cycle_addr_o(sca),
    .parity_err_o(perr));
  addr_phase_device addr_phase_device_i2 (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(ifb),
    .dual_mode_i(1'b0), .cycle_req_i(1'b0), .cycle_addr_i(32'h0), .cycle_be_i(8'h0),
    .cycle_ack_o(), .lookup_addr_o(), .snoop_valid_o(), .snoop_addr_o(),
    .intctl_enable_o(ien2), .dual_strobe_oe_o());
  addr_phase_chk addr_phase_chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .dev_addr(ifa.dev_addr), .dev_addr_oe(ifa.dev_addr_oe), .dev_par(ifa.dev_par),
    .byte_enable_n(ifa.byte_enable_n), .new_cycle_strobe_n(ifa.new_cycle_strobe_n),
    .cycle_strobe_copy_n(ifa.cycle_strobe_copy_n),
    .address_float_request(ifa.address_float_request),
    .external_snoop_strobe_n(ifa.external_snoop_strobe_n),
    .inquire_parity_error_n(ifa.inquire_parity_error_n),
    .address_lines(ifa.address_lines), .address_parity(ifa.address_parity));
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Own cycle; waits for the system end to see it
  task automatic cyc(input logic [31:0] a, input logic [7:0] b, input logic [31:0] exp);
    int n;
    caddr = a;
    cbe = b;
    creq = 1'b1;
    tick(1);
    creq = 1'b0;
    chk({31'h0, ack}, 32'h1);
    be_seen = 8'h0;
    for (n = 0; n < 6 && seen !== 1'b1; n++) begin
      if (ifa.new_cycle_strobe_n === 1'b0) be_seen = ~ifa.byte_enable_n;
      tick(1);
    end
    chk(sca, exp & 32'hfffffff8);
    chk({24'h0, be_seen}, {24'h0, b});
    chk(lka, exp);
    tick(1);
  endtask
  // Bench acts as system on the second interface; flip spoils parity
  task automatic snoop_b(input logic [28:0] a, input logic flip);
    ifb.sys_addr = a;
    ifb.sys_addr_oe = 1'b1;
    ifb.sys_par = (^a) ^ flip;
    ifb.external_snoop_strobe_n = 1'b0;
    tick(1);
    ifb.external_snoop_strobe_n = 1'b1;
    ifb.sys_addr_oe = 1'b0;
    chk({31'h0, ifb.inquire_parity_error_n}, 32'h1);
    tick(1);
    chk({31'h0, ifb.inquire_parity_error_n}, {31'h0, ~flip});
    tick(1);
    chk({31'h0, ifb.inquire_parity_error_n}, 32'h1);
  endtask
  initial begin
    #20000;
    mismatches++;
    close_out();
  end
  initial begin
    ifb.sys_addr = 29'h0;
    ifb.sys_addr_oe = 1'b0;
    ifb.sys_par = 1'b0;
    ifb.address_float_request = 1'b0;
    ifb.external_snoop_strobe_n = 1'b1;
    ifb.address_bit20_mask_n = 1'b1;
    ifb.interrupt_bus_data1 = 1'b0;
    tick(5);
    rst_i = 1'b0;
    ifb.address_float_request = 1'b1;
    tick(2);
    chk({31'h0, ien}, 32'h1);
    chk({31'h0, ien2}, 32'h0);
    cyc(32'h0012_345c, 8'h0f, 32'h0012_345c);
    cyc(32'hffef_fff8, 8'hf0, 32'hffef_fff8);
    // Mask honoured, withheld outside real mode, ignored in dual mode
    for (i = 0; i < 3; i++) begin
      rm = (i != 1);
      mr = 1'b1;
      dual = (i == 2);
      tick(3);
      chk({31'h0, doe}, {31'h0, dual});
      cyc(32'h8013_5670, 8'hff, (i == 0) ? 32'h8003_5670 : 32'h8013_5670);
    end
    mr = 1'b0;
    dual = 1'b0;
    // Request under hold is dropped
    hr = 1'b1;
    tick(2);
    creq = 1'b1;
    tick(1);
    creq = 1'b0;
    chk({31'h0, ifa.new_cycle_strobe_n}, 32'h1);
    chk({31'h0, ifa.dev_addr_oe}, 32'h0);
    saddr = 32'hdead_beff;
    sr = 1'b1;
    for (i = 0; i < 8 && sv !== 1'b1; i++) tick(1);
    sr = 1'b0;
    chk(sa, 32'hdead_bee0);
    tick(3);
    chk({31'h0, perr}, 32'h0);
    hr = 1'b0;
    tick(2);
    cyc(32'h0000_0008, 8'h01, 32'h0000_0008);
    tick(2);
    snoop_b(29'h0abc_def1, 1'b0);
    snoop_b(29'h0abc_def1, 1'b1);
    snoop_b(29'h1555_5555, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
